// *** logic/sideband_params.svh ***
// timing, address map and control field constants for the sideband block
`ifndef SIDEBAND_PARAMS_SVH
`define SIDEBAND_PARAMS_SVH

`define CLK_PERIOD_NS        20
`define T_RESET_INIT_NS      10000
`define RESET_INIT_CYC       ((`T_RESET_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W            10

`define LANES                8
`define DEV_ADDR_DEFAULT     7'h50

`define ADDR_FLAGS           8'h00
`define ADDR_CTRL            8'h01
`define RAM_AW               5
`define RAM_PAGE             3'h1

`define CTL_PIN_TX_OFF       0
`define CTL_ALERT_LIGHT_LOSS 1
`define CTL_POWER_OVERRIDE   2
`define CTL_POWER_SET        3
`define CTL_HIGH_CLASS_EN    4
`define CTL_TX_SQUELCH       5
`define CTL_RESET            8'h00

`define PIN_SYNC_INIT        5'h1F

`endif

// *** logic/sideband_pkg.sv ***
// types shared by the sideband control files
package sideband_pkg;

  typedef enum logic [3:0]
  {
    ST_ADDR     = 4'h0,
    ST_ADDR_ACK = 4'h1,
    ST_PTR      = 4'h2,
    ST_PTR_ACK  = 4'h3,
    ST_WDATA    = 4'h4,
    ST_WACK     = 4'h5,
    ST_RDATA    = 4'h6,
    ST_RACK     = 4'h7,
    ST_IDLE     = 4'h8
  } link_state_e;

  typedef enum logic [1:0]
  {
    PWR_LOW   = 2'h0,
    PWR_HIGH  = 2'h1,
    PWR_UPPER = 2'h2
  } power_class_e;

endpackage

// *** logic/level_sync.sv ***
// two flip-flop synchroniser for a group of levels
module level_sync
#(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= INIT;
      q      <= INIT;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** logic/byte_ram.sv ***
// small byte memory with registered read data
module byte_ram
#(
  parameter int AW = 5
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule

// *** logic/sideband_ctrl.sv ***
// sideband control of a pluggable optical module: pins, serial slave, flags
`include "sideband_params.svh"
module sideband_ctrl
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)
(
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        scl_clk,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe,
  input  wire logic                        module_select_n,
  input  wire logic                        module_reset_n,
  input  wire logic                        low_power_tx_off_pin,
  output logic                             presence_n,
  output logic                             alert_or_light_loss_n_o,
  output logic                             alert_or_light_loss_n_oe,
  input  wire logic [`LANES-1:0]           lane_light_lost,
  input  wire logic [`LANES-1:0]           cdr_los,
  output logic      [`LANES-1:0]           tx_disable,
  output logic      [`LANES-1:0]           tx_modulation_off,
  output logic      [`LANES-1:0]           recovered_clock_path_squelch,
  output logic                             low_power_active,
  output sideband_pkg::power_class_e       power_class,
  output logic                             in_reset
);
  import sideband_pkg::*;

  logic                 sel_n_s;
  logic                 reset_n_s;
  logic                 pin_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 sda_d_r;
  logic                 scl_d_r;
  logic                 start_det;
  logic                 stop_det;
  logic                 frame_r;
  logic                 frame_rst_n_r;
  logic [`RST_CNT_W-1:0] rst_cnt_r;
  logic                 ctl_rst_n_r;
  logic [`LANES-1:0]    los_s;
  logic [`LANES-1:0]    cdr_los_s;
  logic [`LANES-1:0]    los_prev_r;
  logic [7:0]           ctl_s;
  logic [7:0]           flags_r;
  logic [7:0]           flags_nxt;
  logic                 clr_tgl_s;
  logic                 clr_tgl_d_r;
  logic                 clr_pulse;
  logic                 low_power_request;
  logic                 transmit_off;
  logic                 alert_drive_r;
  logic                 low_power_nxt;

  link_state_e          state_r;
  logic [2:0]           bit_cnt_r;
  logic [7:0]           rx_sh_r;
  logic [7:0]           rx_byte;
  logic                 rd_r;
  logic [7:0]           ptr_r;
  logic [7:0]           ctl_r;
  logic [7:0]           flags_link_s;
  logic [7:0]           flag_snap_r;
  logic                 flag_tgl_r;
  logic [7:0]           ram_rdata;
  logic [7:0]           read_byte;
  logic                 byte_end;
  logic                 wr_en;
  logic                 ram_hit;
  logic                 sda_drive_r;

  // input synchronisers, sys domain
  level_sync #(.W(5), .INIT(`PIN_SYNC_INIT)) u_pin_sync
  (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({module_select_n, module_reset_n, low_power_tx_off_pin,
             scl_clk, sda_i}),
    .q     ({sel_n_s, reset_n_s, pin_s, scl_s, sda_s})
  );

  level_sync #(.W(2*`LANES)) u_lane_sync
  (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({lane_light_lost, cdr_los}),
    .q     ({los_s, cdr_los_s})
  );

  level_sync #(.W(8), .INIT(`CTL_RESET)) u_ctl_sync
  (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (ctl_r),
    .q     (ctl_s)
  );

  level_sync #(.W(1)) u_clr_sync
  (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (flag_tgl_r),
    .q     (clr_tgl_s)
  );

  // flags toward the link domain
  level_sync #(.W(8)) u_flag_sync
  (
    .clk   (scl_clk),
    .rst_b (ctl_rst_n_r),
    .d     (flags_r),
    .q     (flags_link_s)
  );

  // start and stop need the clock high in two samples in a row
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_d_r       <= 1'b1;
      scl_d_r       <= 1'b1;
      frame_r       <= 1'b0;
      frame_rst_n_r <= 1'b0;
    end
    else
    begin
      sda_d_r <= sda_s;
      scl_d_r <= scl_s;
      if (sel_n_s || stop_det)
      begin
        frame_r <= 1'b0;
      end
      else if (start_det)
      begin
        frame_r <= 1'b1;
      end
      frame_rst_n_r <= frame_r & ~start_det & ~stop_det & ~sel_n_s;
    end
  end

  // reset pulse length qualification
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_cnt_r   <= '0;
      in_reset    <= 1'b0;
      ctl_rst_n_r <= 1'b0;
    end
    else
    begin
      if (reset_n_s)
      begin
        rst_cnt_r <= '0;
        in_reset  <= 1'b0;
      end
      else if (rst_cnt_r == `RST_CNT_W'(`RESET_INIT_CYC - 1))
      begin
        in_reset <= 1'b1;
      end
      else
      begin
        rst_cnt_r <= rst_cnt_r + 1'b1;
      end
      ctl_rst_n_r <= ~in_reset;
    end
  end

  // latched flags, set wins over clear
  assign clr_pulse = clr_tgl_s ^ clr_tgl_d_r;

  always_comb
  begin
    flags_nxt = flags_r;
    if (clr_pulse)
    begin
      flags_nxt = flags_nxt & ~flag_snap_r;
    end
    flags_nxt = flags_nxt | (los_s ^ los_prev_r);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_r     <= '0;
      los_prev_r  <= '0;
      clr_tgl_d_r <= 1'b0;
    end
    else
    begin
      flags_r     <= in_reset ? 8'h00 : flags_nxt;
      los_prev_r  <= los_s;
      clr_tgl_d_r <= clr_tgl_s;
    end
  end

  // dual-mode input interpretation and power
  assign low_power_request = ~ctl_s[`CTL_PIN_TX_OFF] & pin_s;
  assign transmit_off      = ctl_s[`CTL_PIN_TX_OFF] & pin_s;
  assign low_power_nxt     = ctl_s[`CTL_POWER_OVERRIDE] ?
                             ctl_s[`CTL_POWER_SET] : low_power_request;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_power_active             <= 1'b1;
      power_class                  <= PWR_LOW;
      tx_disable                   <= '1;
      tx_modulation_off            <= '0;
      recovered_clock_path_squelch <= '0;
      alert_drive_r                <= 1'b0;
    end
    else
    begin
      low_power_active <= low_power_nxt;
      if (low_power_nxt)
      begin
        power_class <= PWR_LOW;
      end
      else if (ctl_s[`CTL_HIGH_CLASS_EN])
      begin
        power_class <= PWR_UPPER;
      end
      else
      begin
        power_class <= PWR_HIGH;
      end
      tx_disable <=
        {`LANES{~reset_n_s | transmit_off}};
      tx_modulation_off <= {`LANES{ctl_s[`CTL_TX_SQUELCH]}};
      recovered_clock_path_squelch <= cdr_los_s;
      if (ctl_s[`CTL_ALERT_LIGHT_LOSS])
      begin
        alert_drive_r <= |los_s;
      end
      else
      begin
        alert_drive_r <= |flags_r;
      end
    end
  end

  assign presence_n              = 1'b0;
  assign alert_or_light_loss_n_o  = 1'b0;
  assign alert_or_light_loss_n_oe = alert_drive_r;
  assign sda_o                   = 1'b0;
  assign sda_oe                  = sda_drive_r & frame_rst_n_r;

  // serial slave, link domain; never holds the clock low
  assign rx_byte  = {rx_sh_r[6:0], sda_i};
  assign byte_end = (bit_cnt_r == 3'h7);
  assign ram_hit  = (ptr_r[7:`RAM_AW] == `RAM_PAGE);
  assign wr_en    = (state_r == ST_WDATA) && byte_end;

  always_ff @(posedge scl_clk or negedge frame_rst_n_r)
  begin
    if (!frame_rst_n_r)
    begin
      state_r   <= ST_ADDR;
      bit_cnt_r <= '0;
      rx_sh_r   <= '0;
      rd_r      <= 1'b0;
    end
    else
    begin
      rx_sh_r <= rx_byte;
      case (state_r)
        ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA:
        begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
          if (byte_end)
          begin
            case (state_r)
              ST_ADDR:
              begin
                rd_r    <= rx_byte[0];
                state_r <= (rx_byte[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              end
              ST_PTR:   state_r <= ST_PTR_ACK;
              ST_WDATA: state_r <= ST_WACK;
              default:  state_r <= ST_RACK;
            endcase
          end
        end
        ST_ADDR_ACK:
        begin
          bit_cnt_r <= '0;
          state_r   <= rd_r ? ST_RDATA : ST_PTR;
        end
        ST_PTR_ACK, ST_WACK:
        begin
          bit_cnt_r <= '0;
          state_r   <= ST_WDATA;
        end
        ST_RACK:
        begin
          bit_cnt_r <= '0;
          state_r   <= sda_i ? ST_IDLE : ST_RDATA;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // pointer, control byte and flag snapshot survive repeated starts
  always_ff @(posedge scl_clk or negedge ctl_rst_n_r)
  begin
    if (!ctl_rst_n_r)
    begin
      ptr_r       <= '0;
      ctl_r       <= `CTL_RESET;
      flag_snap_r <= '0;
      flag_tgl_r  <= 1'b0;
    end
    else
    begin
      if (state_r == ST_PTR && byte_end)
      begin
        ptr_r <= rx_byte;
      end
      else if ((state_r == ST_WDATA || state_r == ST_RDATA) && byte_end)
      begin
        ptr_r <= ptr_r + 1'b1;
      end
      if (wr_en && ptr_r == `ADDR_CTRL)
      begin
        ctl_r <= rx_byte;
      end
      if ((state_r == ST_ADDR_ACK && rd_r) || (state_r == ST_RACK && !sda_i))
      begin
        flag_snap_r <= flags_link_s;
      end
      if (state_r == ST_RDATA && byte_end && ptr_r == `ADDR_FLAGS)
      begin
        flag_tgl_r <= ~flag_tgl_r;
      end
    end
  end

  byte_ram #(.AW(`RAM_AW)) u_ram
  (
    .clk   (scl_clk),
    .we    (wr_en && ram_hit),
    .waddr (ptr_r[`RAM_AW-1:0]),
    .wdata (rx_byte),
    .raddr (ptr_r[`RAM_AW-1:0]),
    .rdata (ram_rdata)
  );

  always_comb
  begin
    if (ptr_r == `ADDR_FLAGS)
    begin
      read_byte = flag_snap_r;
    end
    else if (ptr_r == `ADDR_CTRL)
    begin
      read_byte = ctl_r;
    end
    else if (ram_hit)
    begin
      read_byte = ram_rdata;
    end
    else
    begin
      read_byte = 8'h00;
    end
  end

  // data and acknowledge change while the clock is low
  always_ff @(negedge scl_clk or negedge frame_rst_n_r)
  begin
    if (!frame_rst_n_r)
    begin
      sda_drive_r <= 1'b0;
    end
    else
    begin
      sda_drive_r <= (state_r == ST_ADDR_ACK) || (state_r == ST_PTR_ACK) ||
                     (state_r == ST_WACK) ||
                     ((state_r == ST_RDATA) &&
                      !read_byte[3'h7 - bit_cnt_r]);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_desel_no_ack: assert property (sel_n_s |=> !sda_oe)
    else $error("sda driven while deselected");
  a_tx_held_reset: assert property (!reset_n_s |=> &tx_disable)
    else $error("transmitter enabled in reset");
  a_mode_exclusive: assert property
    (!(low_power_request && transmit_off))
    else $error("both pin functions active");
  a_txoff_disable: assert property
    (ctl_s[`CTL_PIN_TX_OFF] && pin_s |=>
     &tx_disable && !$past(low_power_request))
    else $error("tx-off mode did not disable");
  a_alert_flags: assert property
    (!ctl_s[`CTL_ALERT_LIGHT_LOSS] |=>
     alert_or_light_loss_n_oe == $past(|flags_r))
    else $error("alert not OR of flags");
  a_flag_sticky: assert property
    (!clr_pulse && !in_reset |=>
     (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag lost without read");
  a_light_loss: assert property
    (ctl_s[`CTL_ALERT_LIGHT_LOSS] && |los_s |=> alert_or_light_loss_n_oe)
    else $error("lane loss not reported");

  // qualified reset held long enough to reach the system copy
  sequence reset_held_seq;
    in_reset [*4];
  endsequence

  a_reset_defaults: assert property
    (reset_held_seq |-> ctl_s == `CTL_RESET)
    else $error("settings kept in reset");
  a_power_low: assert property
    (low_power_nxt |=> low_power_active && power_class == PWR_LOW)
    else $error("power class wrong");
  a_rx_squelch: assert property
    (|cdr_los_s |=> recovered_clock_path_squelch == $past(cdr_los_s))
    else $error("recovered clock not squelched");
  a_squelch_mod: assert property
    (ctl_s[`CTL_TX_SQUELCH] && reset_n_s && !transmit_off |=>
     &tx_modulation_off && !(|tx_disable))
    else $error("squelch turned laser off");
endmodule

// *** dv/host_ctrl_model.sv ***
// host controller model: select pin and serial bus master
module host_ctrl_model
#(
  parameter logic [6:0] DEV_ADDR   = 7'h50,
  parameter int         T_ASSERT   = 4,
  parameter int         T_DEASSERT = 4
)
(
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl_clk,
  output logic      sda_low,
  output logic      select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ok;
  logic [7:0] rd_buf [32];
  initial
  begin
    scl_clk  = 1'b1;
    sda_low  = 1'b0;
    select_n = 1'b1;
    ok       = 1'b0;
  end
  // one bit per 32 ns: clock low 24 ns, high 8 ns, so no two system
  // samples in a row see it high across a data change; high between frames
  task automatic bit_out(input logic b);
    scl_clk = 1'b0;
    #8 sda_low = ~b;
    #16 scl_clk = 1'b1;
    #8;
  endtask
  task automatic bit_in(output logic v);
    scl_clk = 1'b0;
    #8 sda_low = 1'b0;
    #16 scl_clk = 1'b1;
    #4 v = sda_line;
    #4;
  endtask
  // start and stop are held long so the sampled copies see them
  task automatic start_cond();
    scl_clk = 1'b0;
    #8 sda_low = 1'b0;
    #16 scl_clk = 1'b1;
    #80 sda_low = 1'b1;
    #80;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack_ok);
    logic v;
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    bit_in(v);
    ack_ok = ~v;
  endtask
  task automatic get_byte(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(b[i]);
    bit_out(last);
  endtask
  task automatic frame_begin(input logic sel);
    @(negedge sys_clk);
    select_n = ~sel;
    repeat (T_ASSERT) @(negedge sys_clk);
    #3;
    start_cond();
  endtask
  task automatic frame_end();
    scl_clk = 1'b0;
    #8 sda_low = 1'b1;
    #16 scl_clk = 1'b1;
    #80 sda_low = 1'b0;
    #80;
    @(negedge sys_clk);
    select_n = 1'b1;
    repeat (T_DEASSERT) @(negedge sys_clk);
  endtask
  task automatic wr(input logic sel, input logic [7:0] ptr, input int n,
                    input logic [7:0] first);
    logic a;
    frame_begin(sel);
    put_byte({DEV_ADDR, 1'b0}, a);
    ok = a;
    put_byte(ptr, a);
    ok = ok & a;
    for (int i = 0; i < n; i++)
    begin
      put_byte(first + 8'(i), a);
      ok = ok & a;
    end
    frame_end();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    frame_begin(1'b1);
    put_byte({DEV_ADDR, 1'b0}, a);
    ok = a;
    put_byte(ptr, a);
    ok = ok & a;
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, a);
    ok = ok & a;
    for (int i = 0; i < n; i++)
      get_byte(rd_buf[i], i == n - 1);
    frame_end();
  endtask
endmodule

// *** dv/module_sideband_control_tb.sv ***
// self-checking bench of the sideband control block
`include "sideband_params.svh"
module module_sideband_control_tb;
  import sideband_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk = 1'b0;
  logic               rst_b;
  logic               scl_clk;
  logic               sda_low;
  logic               sda_line;
  logic               sda_o;
  logic               sda_oe;
  logic               module_select_n;
  logic               module_reset_n;
  logic               lp_pin;
  logic               presence_n;
  logic               alert_o;
  logic               alert_oe;
  logic               alert_line;
  logic [`LANES-1:0]  lane_lost;
  logic [`LANES-1:0]  cdr_los;
  logic [`LANES-1:0]  tx_disable;
  logic [`LANES-1:0]  tx_mod_off;
  logic [`LANES-1:0]  rc_squelch;
  logic               low_power_active;
  power_class_e       power_class;
  logic               in_reset;
  int                 failures;
  int                 compares;
  always #10 sys_clk = ~sys_clk;
  assign sda_line   = ~(sda_low | (sda_oe & ~sda_o));
  assign alert_line = alert_oe ? alert_o : 1'b1;
  sideband_ctrl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_clk(scl_clk),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_tx_off_pin(lp_pin), .presence_n(presence_n),
    .alert_or_light_loss_n_o(alert_o), .alert_or_light_loss_n_oe(alert_oe),
    .lane_light_lost(lane_lost), .cdr_los(cdr_los), .tx_disable(tx_disable),
    .tx_modulation_off(tx_mod_off), .recovered_clock_path_squelch(rc_squelch),
    .low_power_active(low_power_active), .power_class(power_class),
    .in_reset(in_reset));
  host_ctrl_model i_host (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl_clk(scl_clk), .sda_low(sda_low), .select_n(module_select_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // lets a serial write cross into the system domain and land
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic apply(input logic [7:0] ctl, input logic pin,
                       input logic [7:0] td, input logic lp,
                       input power_class_e cls);
    lp_pin = pin;
    i_host.wr(1'b1, `ADDR_CTRL, 1, ctl);
    settle();
    check(tx_disable, td);
    check(low_power_active, lp);
    check(power_class, cls);
  endtask
  task automatic t_select();
    i_host.wr(1'b0, `ADDR_CTRL, 1, 8'h20);
    check(i_host.ok, 1'b0);
    settle();
    check(tx_mod_off, 8'h00);
    i_host.wr(1'b1, `ADDR_CTRL, 1, 8'h20);
    check(i_host.ok, 1'b1);
    settle();
    check(tx_mod_off, 8'hFF);
    check(tx_disable, 8'h00);
    i_host.rd(`ADDR_CTRL, 1);
    check(i_host.rd_buf[0], 8'h20);
    $display("test select done");
  endtask
  task automatic t_power();
    apply(8'h00, 1'b1, 8'h00, 1'b1, PWR_LOW);
    apply(8'h01, 1'b1, 8'hFF, 1'b0, PWR_HIGH);
    apply(8'h01, 1'b0, 8'h00, 1'b0, PWR_HIGH);
    apply(8'h0C, 1'b0, 8'h00, 1'b1, PWR_LOW);
    apply(8'h04, 1'b1, 8'h00, 1'b0, PWR_HIGH);
    apply(8'h05, 1'b1, 8'hFF, 1'b0, PWR_HIGH);
    apply(8'h14, 1'b0, 8'h00, 1'b0, PWR_UPPER);
    apply(8'h00, 1'b0, 8'h00, 1'b0, PWR_HIGH);
    $display("test power done");
  endtask
  task automatic t_flags();
    lane_lost = 8'h04;
    settle();
    check(alert_line, 1'b0);
    lane_lost = 8'h00;
    settle();
    i_host.rd(`ADDR_FLAGS, 1);
    check(i_host.rd_buf[0], 8'h04);
    settle();
    check(alert_line, 1'b1);
    i_host.wr(1'b1, `ADDR_CTRL, 1, 8'h02);
    settle();
    check(alert_line, 1'b1);
    lane_lost = 8'h80;
    settle();
    check(alert_line, 1'b0);
    lane_lost = 8'h00;
    settle();
    check(alert_line, 1'b1);
    i_host.wr(1'b1, `ADDR_CTRL, 1, 8'h00);
    settle();
    check(alert_line, 1'b0);
    i_host.rd(`ADDR_FLAGS, 1);
    check(i_host.rd_buf[0], 8'h80);
    settle();
    check(alert_line, 1'b1);
    cdr_los = 8'hA5;
    settle();
    check(rc_squelch, 8'hA5);
    cdr_los = 8'h00;
    settle();
    check(rc_squelch, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_burst();
    i_host.wr(1'b1, 8'h20, 32, 8'h40);
    check(i_host.ok, 1'b1);
    i_host.rd(8'h20, 32);
    for (int i = 0; i < 32; i++)
      check(i_host.rd_buf[i], 8'h40 + 8'(i));
    i_host.rd(8'h10, 1);
    check(i_host.rd_buf[0], 8'h00);
    $display("test burst done");
  endtask
  task automatic t_mod_reset();
    int k;
    i_host.wr(1'b1, `ADDR_CTRL, 1, 8'h20);
    settle();
    module_reset_n = 1'b0;
    k = 0;
    while (in_reset !== 1'b1 && k < 600)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 600)
    begin
      failures++;
      tally_and_finish();
    end
    check(k >= `RESET_INIT_CYC, 1'b1);
    check(tx_disable, 8'hFF);
    settle();
    check(tx_mod_off, 8'h00);
    i_host.wr(1'b1, `ADDR_CTRL, 1, 8'h20);
    check(tx_disable, 8'hFF);
    module_reset_n = 1'b1;
    settle();
    check(in_reset, 1'b0);
    check(tx_mod_off, 8'h00);
    check(tx_disable, 8'h00);
    $display("test module reset done");
  endtask
  initial
  begin
    rst_b          = 1'b0;
    module_reset_n = 1'b1;
    lp_pin         = 1'b1;
    lane_lost      = '0;
    cdr_los        = '0;
    failures       = 0;
    compares       = 0;
    repeat (5) @(negedge sys_clk);
    check(tx_disable, 8'hFF);
    rst_b = 1'b1;
    settle();
    check(presence_n, 1'b0);
    check(alert_line, 1'b1);
    check(low_power_active, 1'b1);
    check(tx_disable, 8'h00);
    $display("test defaults done");
    t_select();
    t_power();
    t_flags();
    t_burst();
    t_mod_reset();
    tally_and_finish();
  end
endmodule
